// ### rtl/acc_clk_div.sv
// Conversion clock divider: one-cycle tick at the chosen rate.
// Assumes the select code is stable or that a glitchy period is harmless.
`timescale 1ns/1ns
module acc_clk_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [2:0] div_sel,
  // Tick
  output logic tick
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // Free counter
  // ----------------------------------------------------------------
  logic [6:0] cnt_reg; // Divider count
  logic [6:0] cnt_next;
  logic [6:0] last_w; // Terminal count = 2^sel - 1
  assign last_w = 7'((8'h01 << div_sel) - 8'h01); // see R13 see R14
  assign cnt_next = (!run || cnt_reg >= last_w) ? 7'h00 : cnt_reg + 7'h01;
  assign tick = run && (cnt_reg >= last_w);

  // Counter restarts when stopped so first tick has a full period
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // acc_clk_div

// ### rtl/acc_ctrl.sv
// What this block does
// R1 - Start after start bit written one then zero
// R2 - Busy rises on start pulse or trigger fall
// R3 - Busy clears when conversion finishes
// R4 - Busy bit is read only
// R5 - Enable bit powers the converter
// R6 - Disabled converter keeps result bytes
// R7 - Alignment bit picks result byte packing
// R8 - Channel codes 0..13 route, others float
// R9 - Source field picks external or internal signal
// R10 - Internal source disconnects external channel
// R11 - Reference codes 00,1x pin, 01 supply
// R12 - Supply reference disconnects reference pin
// R13 - Clock codes 0..3 divide by 1,2,4,8
// R14 - Clock codes 4..7 divide by 16..128
//
// A/D conversion control top: registers, start logic, routing, result.
// Assumes the analog converter returns its 12-bit code on result_data
// by the end of the sequence; all inputs are synchronous to sys_clk.
`timescale 1ns/1ns
module acc_ctrl #(
  parameter int CONV_CLOCKS = acc_pkg::ACC_CONV_CLOCKS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire acc_pkg::acc_bus_t bus,
  output logic [7:0] rdata,
  // Trigger and converter
  input wire logic edge_blanking_trigger,
  input wire logic [11:0] result_data,
  output logic conv_clk_tick,
  output logic sample_now,
  output acc_pkg::acc_route_t route,
  // Interrupt
  output logic irq
);
  import acc_pkg::*;

  // Step counter is 8 bits wide and the last step compares against N-1
  if (CONV_CLOCKS < 2 || CONV_CLOCKS > 255) begin : g_bad_conv_clocks
    $error("CONV_CLOCKS out of range");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_ctrl_w, wr_sel_w, wr_stat_w, wr_mask_w;
  assign wr_ctrl_w = bus.wr && bus.addr == ACC_OFS_CTRL;
  assign wr_sel_w = bus.wr && bus.addr == ACC_OFS_SEL;
  assign wr_stat_w = bus.wr && bus.addr == ACC_OFS_IRQ_STAT;
  assign wr_mask_w = bus.wr && bus.addr == ACC_OFS_IRQ_MASK;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01,
    ACC_DONE = 2'b11
  } acc_state_t;

  acc_state_t state_reg, state_next;
  logic [7:0] ctrl_reg; // Busy bit stored separately, slot unused
  logic [7:0] sel_reg;
  logic [7:0] res_hi_reg, res_lo_reg;
  logic [1:0] stat_reg, mask_reg;
  logic [7:0] cnt_reg, cnt_next;
  logic trig_reg; // Previous trigger level
  logic [7:0] rdata_reg;

  // ----------------------------------------------------------------
  // Start detection
  // ----------------------------------------------------------------
  logic enabled_w, start_fall_w, trig_fall_w, go_w, busy_w;
  assign enabled_w = ctrl_reg[ACC_BIT_EN]; // see R5
  // Start bit stored high, now written low: pulse complete
  assign start_fall_w = wr_ctrl_w && ctrl_reg[ACC_BIT_START]
                        && !bus.wdata[ACC_BIT_START]; // see R1
  assign trig_fall_w = trig_reg && !edge_blanking_trigger; // see R2
  assign busy_w = state_reg != ACC_IDLE; // see R4
  // A new start while converting is ignored; off converter never runs
  assign go_w = enabled_w && !busy_w
                && (start_fall_w || trig_fall_w); // see R2

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic tick_w;
  acc_clk_div u_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(busy_w),
    .div_sel(sel_reg[2:0]),
    .tick(tick_w)
  );
  assign conv_clk_tick = tick_w;
  assign sample_now = state_reg == ACC_DONE;

  // Next state: count converter clocks, then take result
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ACC_IDLE: begin
        cnt_next = 8'h00;
        if (go_w) begin
          state_next = ACC_CONV;
        end
      end
      ACC_CONV: begin
        if (!enabled_w) begin
          state_next = ACC_IDLE; // Power-off aborts, see R6
        end else if (tick_w) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == 8'(CONV_CLOCKS - 1)) begin
            state_next = ACC_DONE;
          end
        end
      end
      ACC_DONE: begin
        state_next = ACC_IDLE; // see R3
      end
      default: begin
        state_next = ACC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Result packing
  // ----------------------------------------------------------------
  logic [7:0] pack_hi_w, pack_lo_w;
  logic store_w;
  assign pack_hi_w = ctrl_reg[ACC_BIT_ALIGN] ? {4'h0, result_data[11:8]}
                     : result_data[11:4]; // see R7
  assign pack_lo_w = ctrl_reg[ACC_BIT_ALIGN] ? result_data[7:0]
                     : {result_data[3:0], 4'h0}; // see R7
  assign store_w = state_reg == ACC_DONE && enabled_w; // see R6

  // ----------------------------------------------------------------
  // Analog routing
  // ----------------------------------------------------------------
  logic [2:0] src_w;
  logic ext_src_w;
  assign src_w = sel_reg[7:5];
  assign ext_src_w = src_w == ACC_SRC_EXT || src_w > ACC_SRC_VSS; // see R9
  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_ch
      // Internal source forces every channel off, see R10
      assign route.channel_on[gi] = enabled_w && ext_src_w
                                    && ctrl_reg[3:0] == 4'(gi)
                                    && ctrl_reg[3:0] <= ACC_LAST_CHANNEL;
      // Codes 14 and 15 match no switch, input floats, see R8
    end
  endgenerate
  // Note channel field lives in control register low nibble
  assign route.bandgap_on = enabled_w && src_w == ACC_SRC_BANDGAP; // see R9
  assign route.amp_a_on = enabled_w && src_w == ACC_SRC_AMP_A;
  assign route.amp_b_on = enabled_w && src_w == ACC_SRC_AMP_B;
  assign route.vss_on = enabled_w && src_w == ACC_SRC_VSS;
  assign route.supply_ref_on = enabled_w
                               && sel_reg[4:3] == 2'b01; // see R11
  assign route.ext_ref_on = enabled_w
                            && sel_reg[4:3] != 2'b01; // see R12
  assign route.powered = enabled_w; // see R5

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] ctrl_view_w, rd_mux_w;
  assign ctrl_view_w = {ctrl_reg[7], busy_w, ctrl_reg[5:0]}; // see R4
  assign rd_mux_w = bus.addr == ACC_OFS_CTRL ? ctrl_view_w
                  : bus.addr == ACC_OFS_SEL ? sel_reg
                  : bus.addr == ACC_OFS_RES_HI ? res_hi_reg
                  : bus.addr == ACC_OFS_RES_LO ? res_lo_reg
                  : bus.addr == ACC_OFS_IRQ_STAT ? {6'h00, stat_reg}
                  : bus.addr == ACC_OFS_IRQ_MASK ? {6'h00, mask_reg}
                  : 8'h00; // Unmapped reads zero
  assign rdata = rdata_reg;
  assign irq = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // Interrupt status: set beats clear
  // ----------------------------------------------------------------
  logic [1:0] ev_w, stat_next;
  assign ev_w[ACC_BIT_IRQ_DONE] = store_w;
  assign ev_w[ACC_BIT_IRQ_START] = go_w;
  assign stat_next = (stat_reg & ~(wr_stat_w ? bus.wdata[1:0] : 2'h0))
                     | ev_w;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control and select; busy slot is never written, see R4
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= ACC_CTRL_RST;
      sel_reg <= ACC_SEL_RST;
      mask_reg <= 2'h0;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_reg <= bus.wdata & ~(8'h01 << ACC_BIT_BUSY);
      end
      if (wr_sel_w) begin
        sel_reg <= bus.wdata;
      end
      if (wr_mask_w) begin
        mask_reg <= bus.wdata[1:0];
      end
    end
  end

  // Sequencer, trigger history, status
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ACC_IDLE;
      cnt_reg <= 8'h00;
      trig_reg <= 1'b0;
      stat_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      trig_reg <= edge_blanking_trigger;
      stat_reg <= stat_next;
    end
  end

  // Result bytes hold unless a finished conversion stores, see R6
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      res_hi_reg <= 8'h00;
      res_lo_reg <= 8'h00;
    end else if (store_w) begin
      res_hi_reg <= pack_hi_w;
      res_lo_reg <= pack_lo_w;
    end
  end

  // Read data registered: valid the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus.rd ? rd_mux_w : 8'h00;
    end
  end
endmodule // acc_ctrl

// ### rtl/acc_pkg.sv
// Package for the A/D conversion control block.
// Assumes a single system clock domain and an 8-bit register port.
package acc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] ACC_OFS_CTRL = 3'h0; // Conversion control
  localparam logic [2:0] ACC_OFS_SEL = 3'h1; // Source/reference/clock
  localparam logic [2:0] ACC_OFS_RES_HI = 3'h2; // Result high byte
  localparam logic [2:0] ACC_OFS_RES_LO = 3'h3; // Result low byte
  localparam logic [2:0] ACC_OFS_IRQ_STAT = 3'h4; // Sticky status
  localparam logic [2:0] ACC_OFS_IRQ_MASK = 3'h5; // Interrupt mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACC_BIT_START = 7;
  localparam int ACC_BIT_BUSY = 6;
  localparam int ACC_BIT_EN = 5;
  localparam int ACC_BIT_ALIGN = 4;
  localparam int ACC_BIT_IRQ_DONE = 0;
  localparam int ACC_BIT_IRQ_START = 1;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [7:0] ACC_SEL_RST = 8'h00;
  localparam logic [3:0] ACC_LAST_CHANNEL = 4'hD; // Codes above float
  localparam int ACC_CONV_CLOCKS = 16; // Converter clocks per result

  // Input source codes
  typedef enum logic [2:0] {
    ACC_SRC_EXT = 3'h0,
    ACC_SRC_BANDGAP = 3'h1,
    ACC_SRC_AMP_A = 3'h2,
    ACC_SRC_AMP_B = 3'h3,
    ACC_SRC_VSS = 3'h4
  } acc_src_t;

  // Register access port
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acc_bus_t;

  // Analog routing controls
  typedef struct packed {
    logic [13:0] channel_on; // One-hot external channel switch
    logic bandgap_on;
    logic amp_a_on;
    logic amp_b_on;
    logic vss_on;
    logic ext_ref_on; // External reference pin connected
    logic supply_ref_on; // Supply used as reference
    logic powered; // Converter powered
  } acc_route_t;

endpackage

// ### tb/acc_conv_model.sv
// Converter model: returns a fixed code for each routed source.
// Assumes the route levels of the control block, one clock.
`timescale 1ns/1ns
module acc_conv_model (
  // Clock
  input wire logic sys_clk,
  // Routing in, code out
  input wire acc_pkg::acc_route_t route,
  output logic [11:0] result_data
);
  import acc_pkg::*;
  logic [11:0] last_reg; // Last code driven
  logic [11:0] code; // Code for the routed source
  // Floating or unpowered input wanders, so a stale code never matches
  always_comb begin
    code = ~last_reg;
    for (int k = 0; k < 14; k++) begin
      if (route.powered && route.channel_on[k]) begin
        code = {8'h5C, 4'(k)};
      end
    end
    if (route.powered && route.bandgap_on) code = 12'hB01;
    if (route.powered && route.amp_a_on) code = 12'hA02;
    if (route.powered && route.amp_b_on) code = 12'hA03;
    if (route.powered && route.vss_on) code = 12'h000;
  end
  always_ff @(posedge sys_clk) last_reg <= code;
  assign result_data = code;
endmodule // acc_conv_model

// ### tb/acc_ctrl_assertions.sv
// Checker for the conversion control ports.
// Assumes it is bound onto acc_ctrl; one clock, reset active high.
`timescale 1ns/1ns
module acc_ctrl_assertions #(
  parameter int CONV_CLOCKS = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire acc_pkg::acc_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic edge_blanking_trigger,
  input wire logic [11:0] result_data,
  input wire logic conv_clk_tick,
  input wire logic sample_now,
  input wire acc_pkg::acc_route_t route,
  input wire logic irq
);
  import acc_pkg::*;
  localparam int WAIT_MAX = 600; // Slowest divider with short counts
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  read_quiet_a: assert property ((!bus.rd || bus.addr > 3'h5) |=>
    rdata == 8'h00)
    else $error("rdata set without a mapped read");
  power_off_a: assert property (!route.powered |-> route == '0)
    else $error("routing active while disabled");
  src_exclusive_a: assert property ((route.bandgap_on || route.amp_a_on ||
    route.amp_b_on || route.vss_on) |-> route.channel_on == 14'h0)
    else $error("external channel joined to internal source");
  chan_onehot_a: assert property ($onehot0(route.channel_on))
    else $error("more than one channel switched on");
  ref_exclusive_a: assert property (route.powered |->
    (route.ext_ref_on ^ route.supply_ref_on))
    else $error("reference pin and supply both or neither on");
  done_pulse_a: assert property (sample_now |=>
    !sample_now && !conv_clk_tick)
    else $error("conversion did not end after sampling");
  trig_start_a: assert property ($fell(edge_blanking_trigger) && route.powered
    |-> ##[1:WAIT_MAX] sample_now)
    else $error("trigger fall gave no conversion");
  tick_off_a: assert property (!route.powered |=> !conv_clk_tick)
    else $error("converter clock while disabled");
endmodule // acc_ctrl_assertions
bind acc_ctrl acc_ctrl_assertions #(.CONV_CLOCKS(CONV_CLOCKS))
  acc_ctrl_assertions_i (
  .sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata),
  .edge_blanking_trigger(edge_blanking_trigger), .result_data(result_data),
  .conv_clk_tick(conv_clk_tick), .sample_now(sample_now), .route(route),
  .irq(irq));

// ### tb/acc_ctrl_bench.sv
// Bench for the conversion control block: register tasks and sequences.
// Assumes the converter model on the result input, one 10 MHz clock.
`timescale 1ns/1ns
module acc_ctrl_bench;
  import acc_pkg::*;
  localparam int CONV = 2; // Short conversions keep the run brief
  logic sys_clk, reset, edge_blanking_trigger, conv_clk_tick, sample_now, irq;
  acc_bus_t bus;
  logic [7:0] rdata;
  logic [11:0] result_data, v;
  logic [3:0] ch;
  logic al;
  acc_route_t route;
  int n_fail = 0, checks = 0, cyc = 0, n_samp = 0, t, s0;
  acc_ctrl #(.CONV_CLOCKS(CONV)) acc_ctrl_i (.sys_clk(sys_clk),
    .reset(reset), .bus(bus), .rdata(rdata),
    .edge_blanking_trigger(edge_blanking_trigger),
    .result_data(result_data), .conv_clk_tick(conv_clk_tick),
    .sample_now(sample_now), .route(route), .irq(irq));
  acc_conv_model acc_conv_model_i (.sys_clk(sys_clk), .route(route),
    .result_data(result_data));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Cycle count, sample count and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (sample_now === 1'b1) n_samp <= n_samp + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] w);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(logic [2:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 check($sformatf("reg%0d", a), rdata, exp);
  endtask
  task automatic conv_wait();
    t = 0;
    while (sample_now !== 1'b1 && t < 400) begin
      @(negedge sys_clk);
      t++;
    end
    check("sample_now", sample_now, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    bus = '0;
    edge_blanking_trigger = 1'b0;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(ACC_OFS_CTRL, ACC_CTRL_RST);
    rdc(ACC_OFS_SEL, ACC_SEL_RST);
    // Every source, reference and divider code in one pass
    for (int i = 0; i < 8; i++) begin
      ch = 4'(2 * i + 1);
      al = i[0];
      wr(ACC_OFS_SEL, {3'(i), 2'(i), 3'(i)});
      wr(ACC_OFS_CTRL, {3'b101, al, ch});
      wr(ACC_OFS_CTRL, {3'b001, al, ch});
      t = 0;
      while (conv_clk_tick !== 1'b1 && t < 300) begin
        @(negedge sys_clk);
        t++;
      end
      check("src", {route.bandgap_on, route.amp_a_on, route.amp_b_on,
        route.vss_on}, {i == 1, i == 2, i == 3, i == 4});
      check("chan", route.channel_on, (i == 0 || i == 5 || i == 6) ?
        14'h1 << ch : 14'h0);
      check("ref", {route.ext_ref_on, route.supply_ref_on},
        (i % 4 == 1) ? 2'b01 : 2'b10);
      t = 0;
      do begin
        @(negedge sys_clk);
        t++;
      end while (conv_clk_tick !== 1'b1 && t < 300);
      check("tick", t, 1 << i);
      conv_wait();
      case (i)
        1: v = 12'hB01;
        2: v = 12'hA02;
        3: v = 12'hA03;
        4: v = 12'h000;
        default: v = {8'h5C, ch};
      endcase
      if (i != 7) begin
        rdc(ACC_OFS_RES_HI, al ? {4'h0, v[11:8]} : v[11:4]);
        rdc(ACC_OFS_RES_LO, al ? v[7:0] : {v[3:0], 4'h0});
      end
      rdc(ACC_OFS_CTRL, {3'b001, al, ch});
    end
    // Busy shows during a slow conversion and ignores writes
    wr(ACC_OFS_SEL, 8'h03);
    wr(ACC_OFS_CTRL, 8'hA2);
    wr(ACC_OFS_CTRL, 8'h22);
    rdc(ACC_OFS_CTRL, 8'h62);
    conv_wait();
    wr(ACC_OFS_CTRL, 8'h60);
    rdc(ACC_OFS_CTRL, 8'h20);
    // A held level, low or high, starts nothing
    s0 = n_samp;
    wr(ACC_OFS_CTRL, 8'h20);
    wr(ACC_OFS_CTRL, 8'hA0);
    repeat (200) @(posedge sys_clk);
    check("held", n_samp - s0, 0);
    wr(ACC_OFS_CTRL, 8'h20);
    conv_wait();
    @(posedge sys_clk) edge_blanking_trigger <= 1'b1;
    @(posedge sys_clk) edge_blanking_trigger <= 1'b0;
    conv_wait();
    // Disabled converter keeps its results and stays off
    wr(ACC_OFS_CTRL, 8'h00);
    wr(ACC_OFS_SEL, 8'h20);
    wr(ACC_OFS_CTRL, 8'h80);
    wr(ACC_OFS_CTRL, 8'h00);
    @(negedge sys_clk);
    check("route", route, '0);
    rdc(ACC_OFS_RES_HI, 8'h5C);
    rdc(ACC_OFS_RES_LO, 8'h00);
    // Sticky status, mask and level interrupt
    rdc(ACC_OFS_IRQ_STAT, 8'h03);
    check("irq", irq, 1'b0);
    wr(ACC_OFS_IRQ_MASK, 8'h01);
    repeat (2) @(negedge sys_clk);
    check("irq", irq, 1'b1);
    wr(ACC_OFS_IRQ_STAT, 8'h01);
    repeat (2) @(negedge sys_clk);
    check("irq", irq, 1'b0);
    rdc(ACC_OFS_IRQ_STAT, 8'h02);
    wr(3'h6, 8'hFF);
    rdc(3'h6, 8'h00);
    rdc(3'h7, 8'h00);
    report_and_stop();
  end
endmodule // acc_ctrl_bench
